// ---- ssos_status_out.sv ----
// Functional notes
// - Brake release on when brake frees; timing from stall and motion settings.
// - Servo ready only with control and main power and no alarm.
// - Fault output on when healthy, off in alarm; active low.
// - Low-speed pin function from its select; resets to value 1.
// - Torque-clip pin has its own select, same nine-value encoding.
// - Value 0: on while enabled and torque command is clipped.
// - Value 1: on while motor speed below speed-detect threshold.
// - Value 2: OR of regen, overload, battery, fan and scale warnings.
// - Value 3: on when regen load exceeds 85% of trip level.
// - Value 4: on when load exceeds 85% of overload trip level.
// - Value 5: on when backup battery below about 3.2 V.
// - Value 6: on after fan stalled continuously more than one second.
// - Value 7: scale over 65 degrees or weak signal, full-closed only.
// - Value 8: speed within window of pre-ramp command, velocity/torque only.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
module ssos_status_out
    import ssos_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Drive state, same clock
    input  wire logic               servo_enable,
    input  wire logic               torque_limited,
    input  wire logic               alarm_active,
    input  wire logic signed [15:0] motor_speed,
    input  wire logic signed [15:0] speed_cmd,
    input  wire logic [7:0]         regen_load_pct,
    input  wire logic [7:0]         overload_pct,
    input  wire logic [11:0]        battery_mv,
    input  wire logic [7:0]         scale_temp_c,
    input  wire logic               full_closed_mode,
    input  wire logic               vel_torque_mode,
    // Sensor levels, asynchronous
    input  wire logic               control_power_ok,
    input  wire logic               main_power_ok,
    input  wire logic               fan_stalled,
    input  wire logic               scale_signal_weak,
    // Output stages
    output logic                    brake_release_out,
    output logic                    servo_ready_out,
    output logic                    fault_out_n,
    output logic                    low_speed_out,
    output logic                    torque_clip_out,
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the asynchronous sensor levels
    logic [3:0] sync1_r, sync2_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {scale_signal_weak, fan_stalled, main_power_ok, control_power_ok};
            sync2_r <= sync1_r;
        end
    end
    logic ctl_pwr, main_pwr, fan_stall_s, scale_weak_s;
    assign {scale_weak_s, fan_stall_s, main_pwr, ctl_pwr} = sync2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [3:0]       tclip_sel_r, lspd_sel_r;
    logic [15:0]      speed_thr_r;
    logic [7:0]       brk_stall_ms_r, brk_motion_ms_r;
    logic [N_IRQ-1:0] irq_stat_r, irq_mask_r;
    logic             aw_held_r, w_held_r, wr_go, wr_hit;
    logic [7:0]       awaddr_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;

    // One write at a time; address and data latch in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit        = awaddr_r inside {OFS_PIN_SELECT, OFS_SPEED_THR, OFS_BRAKE_TIME,
                                            OFS_STATUS, OFS_IRQ_STATUS, OFS_IRQ_MASK};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration stores; byte lanes honoured per field
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tclip_sel_r     <= TCLIP_SEL_RST;
            lspd_sel_r      <= LSPD_SEL_RST;
            speed_thr_r     <= SPEED_THR_RST;
            brk_stall_ms_r  <= BRK_TIME_RST;
            brk_motion_ms_r <= BRK_TIME_RST;
            irq_mask_r      <= '0;
        end else if (wr_go) begin
            if (awaddr_r == OFS_PIN_SELECT && wstrb_r[0]) begin
                tclip_sel_r <= wdata_r[TCLIP_SEL_LSB +: 4];
                lspd_sel_r  <= wdata_r[LSPD_SEL_LSB +: 4];
            end
            if (awaddr_r == OFS_SPEED_THR) begin
                if (wstrb_r[0]) speed_thr_r[7:0]  <= wdata_r[7:0];
                if (wstrb_r[1]) speed_thr_r[15:8] <= wdata_r[15:8];
            end
            if (awaddr_r == OFS_BRAKE_TIME) begin
                if (wstrb_r[0]) brk_stall_ms_r  <= wdata_r[BRK_STALL_LSB +: 8];
                if (wstrb_r[1]) brk_motion_ms_r <= wdata_r[BRK_MOTION_LSB +: 8];
            end
            if (awaddr_r == OFS_IRQ_MASK && wstrb_r[0]) begin
                irq_mask_r <= wdata_r[N_IRQ-1:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Millisecond enable; the divider keeps everything on one clock
    logic [$clog2(MS_DIV)-1:0] ms_cnt_r;
    logic                      ms_tick;
    assign ms_tick = (ms_cnt_r == ($clog2(MS_DIV))'(MS_DIV - 1));
    always_ff @(posedge ref_clk) begin
        if (!rst_n || ms_tick) ms_cnt_r <= '0;
        else ms_cnt_r <= ms_cnt_r + 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Speed comparisons in 17 bits to survive the most negative value
    logic [16:0] speed_abs, speed_err, speed_err_abs;
    assign speed_abs     = motor_speed[15] ? 17'(-$signed({motor_speed[15], motor_speed}))
                                           : {1'b0, motor_speed};
    assign speed_err     = 17'($signed({motor_speed[15], motor_speed})
                               - $signed({speed_cmd[15], speed_cmd}));
    assign speed_err_abs = speed_err[16] ? 17'(-$signed(speed_err)) : speed_err;
    // Fan stall must persist past one second before it counts
    logic [10:0] fan_ms_r;
    logic        fan_locked;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !fan_stall_s) fan_ms_r <= 11'h0;
        else if (ms_tick && fan_ms_r <= 11'(FAN_LOCK_MS)) fan_ms_r <= fan_ms_r + 11'h1;
    end
    assign fan_locked = fan_ms_r > 11'(FAN_LOCK_MS);
    // Condition vector, indexed by select code
    logic [N_COND-1:0] cond;
    logic              low_speed;
    assign low_speed = speed_abs < {1'b0, speed_thr_r};
    assign cond[0] = servo_enable && torque_limited;
    assign cond[1] = low_speed;
    assign cond[3] = regen_load_pct > PREWARN_PCT;
    assign cond[4] = overload_pct > PREWARN_PCT;
    assign cond[5] = battery_mv < BATTERY_LOW_MV;
    assign cond[6] = fan_locked;
    assign cond[7] = full_closed_mode && (scale_temp_c > SCALE_HOT_C || scale_weak_s);
    assign cond[8] = vel_torque_mode && speed_err_abs <= {1'b0, speed_thr_r};
    assign cond[2] = |cond[7:3];
    // Both pins share one selector design
    ssos_cond_select #(.NC(N_COND)) u_low_speed_sel (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (cond),
        .sel     (lspd_sel_r),
        .pin_out (low_speed_out)
    );
    ssos_cond_select #(.NC(N_COND)) u_torque_clip_sel (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cond    (cond),
        .sel     (tclip_sel_r),
        .pin_out (torque_clip_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Ready and alarm stages
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            servo_ready_out <= 1'b0;
            fault_out_n     <= 1'b0;
        end else begin
            servo_ready_out <= ctl_pwr && main_pwr && !alarm_active;
            fault_out_n     <= !alarm_active;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Brake: released while driving; after a drop held for the stall delay, or for the motion delay until speed falls below threshold
    ssos_brake_e brk_r;
    logic [7:0]  brk_ms_r;
    logic        drive_on;
    assign drive_on = servo_enable && !alarm_active;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            brk_r    <= BRK_ENGAGED;
            brk_ms_r <= 8'h0;
        end else begin
            case (brk_r)
                BRK_ENGAGED: if (drive_on) brk_r <= BRK_RELEASED;
                BRK_RELEASED: begin
                    brk_ms_r <= 8'h0;
                    if (!drive_on) brk_r <= low_speed ? BRK_HOLD_STALL : BRK_HOLD_MOTION;
                end
                BRK_HOLD_STALL: begin
                    if (drive_on) brk_r <= BRK_RELEASED;
                    else if (brk_ms_r >= brk_stall_ms_r) brk_r <= BRK_ENGAGED;
                    else if (ms_tick) brk_ms_r <= brk_ms_r + 8'h1;
                end
                BRK_HOLD_MOTION: begin
                    if (drive_on) brk_r <= BRK_RELEASED;
                    else if (brk_ms_r >= brk_motion_ms_r || low_speed) brk_r <= BRK_ENGAGED;
                    else if (ms_tick) brk_ms_r <= brk_ms_r + 8'h1;
                end
                default: brk_r <= BRK_ENGAGED;
            endcase
        end
    end
    assign brake_release_out = (brk_r != BRK_ENGAGED);
    ////////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event beats a same-cycle clear
    logic alarm_d_r, warn_d_r, fan_d_r;
    logic [N_IRQ-1:0] irq_set, irq_clr;
    assign irq_set = {fan_locked && !fan_d_r, cond[2] && !warn_d_r, alarm_active && !alarm_d_r};
    assign irq_clr = (wr_go && awaddr_r == OFS_IRQ_STATUS && wstrb_r[0]) ?
                     wdata_r[N_IRQ-1:0] : '0;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
            alarm_d_r  <= 1'b0;
            warn_d_r   <= 1'b0;
            fan_d_r    <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            alarm_d_r  <= alarm_active;
            warn_d_r   <= cond[2];
            fan_d_r    <= fan_locked;
            irq        <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel; answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                OFS_PIN_SELECT: s_axi_rdata <= {24'h0, lspd_sel_r, tclip_sel_r};
                OFS_SPEED_THR:  s_axi_rdata <= {16'h0, speed_thr_r};
                OFS_BRAKE_TIME: s_axi_rdata <= {16'h0, brk_motion_ms_r, brk_stall_ms_r};
                OFS_STATUS:     s_axi_rdata <= {15'h0, cond, brake_release_out, servo_ready_out,
                                    fault_out_n, low_speed_out, torque_clip_out, irq, 2'h0};
                OFS_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_stat_r};
                OFS_IRQ_MASK:   s_axi_rdata <= {29'h0, irq_mask_r};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ready_power_a: assert property (##1 servo_ready_out == $past(ctl_pwr && main_pwr && !alarm_active))
        else $error("Servo ready does not follow power and alarm");
    fault_low_a: assert property (alarm_active |=> !fault_out_n)
        else $error("Fault output not low during alarm");
    brake_on_a: assert property (drive_on |-> ##[1:2] brake_release_out)
        else $error("Brake not released while drive on");
    brake_stall_a: assert property (brk_r == BRK_RELEASED && !drive_on && low_speed
        ##1 !drive_on && brk_stall_ms_r == 8'h0 |=> !brake_release_out)
        else $error("Zero stall delay did not engage brake");
    clip_cond_a: assert property (!servo_enable |-> !cond[0])
        else $error("Clip condition without servo enable");
    warn_or_a: assert property (regen_load_pct > 8'h55 || battery_mv < 12'hc80 |-> cond[2])
        else $error("Warning group misses a warning");
    fan_lock_a: assert property (!fan_stall_s |=> !cond[6])
        else $error("Fan lock without stall");
    scale_mode_a: assert property (!full_closed_mode |-> !cond[7])
        else $error("Scale alarm outside full-closed");
    coin_mode_a: assert property (!vel_torque_mode |-> !cond[8])
        else $error("Speed coincidence outside velocity/torque");
    lspd_default_a: assert property ($rose(rst_n) |-> lspd_sel_r == 4'h1)
        else $error("Low-speed select not 1 after reset");
    overload_a: assert property (overload_pct == 8'h56 |-> cond[4] ##0 overload_pct != 8'h55)
        else $error("Overload pre-warning threshold wrong");
    wr_resp_a: assert property (wr_go |=> s_axi_bvalid)
        else $error("Write response missing");
    brake_hold_c: cover property (brk_r == BRK_HOLD_MOTION ##[1:20] brk_r == BRK_ENGAGED);
    irq_fire_c:   cover property ($rose(irq));
    sel_warn_c:   cover property (lspd_sel_r == 4'h2 && low_speed_out);
endmodule // ssos_status_out

// ---- ssos_pkg.sv ----
package ssos_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and time base
    localparam int CLK_PERIOD_NS  = 8;
    localparam int MS_NS          = 1000000;
    localparam int MS_CYCLES      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAN_LOCK_MS    = 1000;

    ////////////////////////////////////////////////////////////////////////////
    // Condition encoding shared by both selectable pins
    localparam int N_COND         = 9;
    localparam logic [3:0] SEL_TORQUE_CLIP = 4'h0;
    localparam logic [3:0] SEL_LOW_SPEED   = 4'h1;

    // Detection thresholds
    localparam logic [7:0]  PREWARN_PCT    = 8'h55;   // 85 percent of trip level
    localparam logic [11:0] BATTERY_LOW_MV = 12'hc80; // 3200 mV
    localparam logic [7:0]  SCALE_HOT_C    = 8'h41;   // 65 degrees

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_PIN_SELECT  = 8'h00;
    localparam logic [7:0] OFS_SPEED_THR   = 8'h04;
    localparam logic [7:0] OFS_BRAKE_TIME  = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;

    // Field positions
    localparam int TCLIP_SEL_LSB   = 0;
    localparam int LSPD_SEL_LSB    = 4;
    localparam int BRK_STALL_LSB   = 0;
    localparam int BRK_MOTION_LSB  = 8;

    // Reset values
    localparam logic [3:0]  TCLIP_SEL_RST  = SEL_TORQUE_CLIP;
    localparam logic [3:0]  LSPD_SEL_RST   = SEL_LOW_SPEED;
    localparam logic [15:0] SPEED_THR_RST  = 16'h0032;
    localparam logic [7:0]  BRK_TIME_RST   = 8'h00;

    // Interrupt events
    localparam int N_IRQ           = 3;
    localparam int IRQ_ALARM       = 0;
    localparam int IRQ_WARNING     = 1;
    localparam int IRQ_FAN_LOCK    = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BRK_ENGAGED,
        BRK_RELEASED,
        BRK_HOLD_STALL,
        BRK_HOLD_MOTION
    } ssos_brake_e;

endpackage

// ---- ssos_cond_select.sv ----
module ssos_cond_select
    import ssos_pkg::*;
#(
    parameter int NC = N_COND
) (
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    input  wire logic [NC-1:0]   cond,
    input  wire logic [3:0]      sel,
    output logic                 pin_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pick one condition; codes past the table park the pin off
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
        end else if (int'(sel) < NC) begin
            pin_out <= cond[sel];
        end else begin
            pin_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sel_range_off_a: assert property (int'(sel) >= NC |=> !pin_out)
        else $error("Out-of-range select drove the pin");
    sel_follow_a: assert property (int'(sel) < NC |=> pin_out == $past(cond[sel]))
        else $error("Pin does not follow selected condition");

endmodule // ssos_cond_select

// ---- ssos_host_model.sv ----
////////////////////////////////////////////////////////////////////////////////
// Host controller digital inputs watching the drive's transistor stages
module ssos_host_model (
    input  wire logic       ref_clk,
    input  wire logic       brake_release_out,
    input  wire logic       servo_ready_out,
    input  wire logic       fault_out_n,
    input  wire logic       low_speed_out,
    input  wire logic       torque_clip_out,
    output logic [4:0]      host_view
);
    timeunit 1ns;
    timeprecision 1ps;

    // Input stage latches every clock, so the host sees levels one cycle late
    always_ff @(posedge ref_clk) begin
        host_view <= {brake_release_out, servo_ready_out, fault_out_n,
                      low_speed_out, torque_clip_out};
    end
endmodule // ssos_host_model

// ---- testbench.sv ----
module testbench
    import ssos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic servo_enable = 1'b0, torque_limited = 1'b0, alarm_active = 1'b0;
    logic signed [15:0] motor_speed = 16'sh0100, speed_cmd = 16'sh0133;
    logic [7:0] regen_load_pct = 8'h55, overload_pct = 8'h55, scale_temp_c = 8'h41;
    logic [11:0] battery_mv = 12'hc80;
    logic full_closed_mode = 1'b1, vel_torque_mode = 1'b1, control_power_ok = 1'b1;
    logic main_power_ok = 1'b1, fan_stalled = 1'b0, scale_signal_weak = 1'b0;
    logic brake_release_out, servo_ready_out, fault_out_n, low_speed_out;
    logic torque_clip_out, irq;
    logic [4:0] host_view;
    int fails = 0, check_count = 0;

    // Short ms tick keeps the fan-lock wait near four thousand cycles
    ssos_status_out #(.MS_DIV(4)) i_ssos_status_out (.*);
    ssos_host_model i_ssos_host_model (.*);

    // Free-running 125 MHz clock
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Only the watchdog ends a wait for the answer
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdr(OFS_PIN_SELECT);
        chk(rd[7:0], {LSPD_SEL_RST, TCLIP_SEL_RST});
        rdr(8'h40);
        chk(rs, RESP_SLVERR);
        wr(8'h40, 32'h0);
        chk(rs, RESP_SLVERR);
        $display("test reset done");
    endtask

    task automatic t_speed_clip();
        @(posedge ref_clk);
        motor_speed <= 16'sh0031;
        servo_enable <= 1'b1;
        torque_limited <= 1'b1;
        cyc(4);
        chk(low_speed_out, 1'b1);
        chk(torque_clip_out, 1'b1);
        motor_speed <= 16'sh0032;
        servo_enable <= 1'b0;
        cyc(4);
        chk(low_speed_out, 1'b0);
        chk(torque_clip_out, 1'b0);
        torque_limited <= 1'b0;
        $display("test speed and clip done");
    endtask

    // Stall hold of 2 ms is 8 cycles here
    task automatic t_brake();
        wr(OFS_BRAKE_TIME, 32'h0302);
        @(posedge ref_clk);
        servo_enable <= 1'b1;
        motor_speed <= 16'sh0000;
        cyc(4);
        chk(brake_release_out, 1'b1);
        servo_enable <= 1'b0;
        cyc(5);
        chk(brake_release_out, 1'b1);
        cyc(12);
        chk(brake_release_out, 1'b0);
        // Motion hold of 3 ms, cut short once speed falls under threshold
        motor_speed <= 16'sh0100;
        wr(OFS_BRAKE_TIME, 32'h0300);
        chk(rs, RESP_OKAY);
        @(posedge ref_clk);
        servo_enable <= 1'b1;
        cyc(4);
        servo_enable <= 1'b0;
        cyc(3);
        chk(brake_release_out, 1'b1);
        motor_speed <= 16'sh0000;
        cyc(3);
        chk(brake_release_out, 1'b0);
        // Zero stall delay engages at once
        servo_enable <= 1'b1;
        cyc(4);
        chk(brake_release_out, 1'b1);
        servo_enable <= 1'b0;
        cyc(3);
        chk(brake_release_out, 1'b0);
        motor_speed <= 16'sh0100;
        $display("test brake done");
    endtask

    task automatic t_alarm();
        wr(OFS_IRQ_MASK, 32'h1);
        @(posedge ref_clk);
        alarm_active <= 1'b1;
        cyc(4);
        chk(fault_out_n, 1'b0);
        chk(servo_ready_out, 1'b0);
        chk(irq, 1'b1);
        alarm_active <= 1'b0;
        main_power_ok <= 1'b0;
        cyc(5);
        chk(fault_out_n, 1'b1);
        chk(servo_ready_out, 1'b0);
        main_power_ok <= 1'b1;
        cyc(5);
        chk(host_view, 5'b01100);
        wr(OFS_IRQ_STATUS, 32'h1);
        cyc(3);
        chk(irq, 1'b0);
        $display("test alarm done");
    endtask

    // Codes 3 to 8 but 6 get their own condition raised just past the limit; codes 2 and 9 to 15 get overload
    task automatic t_codes();
        for (int c = 2; c < 16; c++) begin
            if (c == 6) continue;
            wr(OFS_PIN_SELECT, {24'h0, 4'h1, c[3:0]});
            cyc(4);
            chk(torque_clip_out, 1'b0);
            case (c)
                3: regen_load_pct <= 8'h56;
                5: battery_mv <= 12'hc7f;
                7: scale_temp_c <= 8'h42;
                8: speed_cmd <= 16'sh0132;
                default: overload_pct <= 8'h56;
            endcase
            cyc(4);
            chk(torque_clip_out, c < 9);
            full_closed_mode <= 1'b0;
            vel_torque_mode <= 1'b0;
            cyc(4);
            chk(torque_clip_out, c < 9 && c != 7 && c != 8);
            full_closed_mode <= 1'b1;
            vel_torque_mode <= 1'b1;
            regen_load_pct <= 8'h55;
            battery_mv <= 12'hc80;
            scale_temp_c <= 8'h41;
            speed_cmd <= 16'sh0133;
            overload_pct <= 8'h55;
        end
        $display("test codes done");
    endtask

    // One second is 4000 cycles at the shortened tick
    task automatic t_fan();
        wr(OFS_PIN_SELECT, 32'h16);
        @(posedge ref_clk);
        fan_stalled <= 1'b1;
        cyc(3990);
        chk(torque_clip_out, 1'b0);
        cyc(60);
        chk(torque_clip_out, 1'b1);
        rdr(OFS_IRQ_STATUS);
        chk(rd[2], 1'b1);
        fan_stalled <= 1'b0;
        $display("test fan done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_speed_clip();
        t_brake();
        t_alarm();
        t_codes();
        t_fan();
        final_report();
    end

    // Watchdog well past the expected four thousand four hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        final_report();
    end
endmodule // testbench
